// File: mqwpf_pkg.sv
// Overview of operation
// - Four almost-full bits, queue n on bit n
// - Unconfigured queue status bits carry no meaning
// - Shared status bus driven by one device only
// - Flag mode pin at reset picks bus ownership
// - Low two select bits pick the queue
// - Upper three select bits must match chip code
// - Direct mode: select bus plus strobe addresses bus
// - Width pins at reset set port widths
// - Narrow data packed little-endian into wide words
// - Full counted in write-port width units
// - Output valid counted in read-port width units
// - One input, one output width for all queues
// - One full flag for active queue, all tracked
// - Full flag shows new queue next edge
// - First write on second edge after select
// - Full flag changes only on clock edges
// - Unselected queues keep updating full status
// - Full flag driven only while chip code matches
package mqwpf_pkg;
	localparam int QUEUES      = 4;           // Queues per device
	localparam int QSEL_W      = 2;           // Queue field of select bus
	localparam int CHIP_W      = 3;           // Chip code width
	localparam int SEL_W       = QSEL_W + CHIP_W;
	localparam int DATA_W      = 36;          // Widest port
	localparam int LVL_W       = 15;          // Level counter width
	localparam int LANES_MAX   = 4;           // x9 lanes per x36 word
	localparam int LANE_W      = 9;           // Narrowest lane
	// Register byte addresses
	localparam logic [7:0] ADDR_CONFIG  = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_AFOFS0  = 8'h10; // Plus four per queue
	localparam logic [7:0] ADDR_LEVEL0  = 8'h20; // Plus four per queue
	// Reset values
	localparam logic [1:0]       CONFIG_RST  = 2'h3; // Four queues
	localparam logic [LVL_W-1:0] AFOFS_RST   = 15'h0008;
	// Status register field positions
	localparam int ST_FULL   = 0;
	localparam int ST_AFULL  = 4;
	localparam int ST_ACTQ   = 8;
	localparam int ST_SEL    = 10;
	localparam int ST_MODE   = 11;
	localparam int ST_CONV   = 12;
	localparam int ST_IW     = 13;
	localparam int ST_OW     = 14;
	localparam int ST_OWNBUS = 15;
	// Ownership of the shared almost-full bus
	typedef enum logic {MQWPF_DIRECT, MQWPF_POLLED} mqwpf_flagmode_e;
endpackage

// File: mqwpf_write_port_flags.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module mqwpf_write_port_flags #(
	parameter int QUEUE_WORDS = 4096         // Depth in 36-bit words
) (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	// Setup pins, caught during master reset; chip code pins used live
	input  wire logic                          flag_bus_mode_select,
	input  wire logic                          width_convert_enable,
	input  wire logic                          input_width_select,
	input  wire logic                          output_width_select,
	input  wire logic                          chip_code_bit0,
	input  wire logic                          chip_code_bit1,
	input  wire logic                          chip_code_bit2,
	// Write port
	input  wire logic [mqwpf_pkg::SEL_W-1:0]   write_queue_select,
	input  wire logic                          write_select_enable,
	input  wire logic                          writeRequest,
	input  wire logic [mqwpf_pkg::DATA_W-1:0]  writeData,
	output logic      [mqwpf_pkg::DATA_W-1:0]  packedWord,
	output logic                               packedValid,
	output logic      [mqwpf_pkg::QSEL_W-1:0]  packedQueue,
	output logic                               queue_full_n,
	output logic                               queueFullOe,
	// Almost-full status bus
	input  wire logic                          almost_full_bus_strobe,
	output logic      [mqwpf_pkg::QUEUES-1:0]  almost_full_status_bus,
	output logic                               almostFullStatusOe,
	// Read port events
	input  wire logic                          readStrobe,
	input  wire logic [mqwpf_pkg::QSEL_W-1:0]  readQueue,
	input  wire logic [mqwpf_pkg::DATA_W-1:0]  readWordIn,
	output logic      [mqwpf_pkg::DATA_W-1:0]  readLaneData,
	output logic      [mqwpf_pkg::QUEUES-1:0]  read_valid_n,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr
);
	import mqwpf_pkg::*;

	// Capacity in 36-bit words, scaled by write lanes below
	localparam logic [LVL_W-1:0] CAP36 = LVL_W'(QUEUE_WORDS);

	// Latched setup
	mqwpf_flagmode_e      flagMode;        // Bus ownership method
	logic                 cfgConv;         // Width conversion on
	logic                 cfgIw;           // Input width pin
	logic                 cfgOw;           // Output width pin
	logic [2:0]           writeLanes;      // Write units per 36 bits
	logic [2:0]           readLanes;       // Read units per 36 bits
	logic [LVL_W-1:0]     capacity;        // Queue size in write units
	// Write select state
	logic [QSEL_W-1:0]    activeQueue;     // Queue selected for writes
	logic                 deviceSelected;  // Upper bits match chip code
	logic                 selPending;      // Edge after a selection
	logic                 writeAccept;     // Write lands this edge
	logic [1:0]           packLane;        // Next narrow lane
	// Per-queue state
	logic [LVL_W-1:0]     level [QUEUES];  // Fill in write units
	logic [1:0]           readSub [QUEUES];// Narrow reads into a unit
	logic [LVL_W-1:0]     afOffset [QUEUES];
	logic [QUEUES-1:0]    fullVec;         // Full per queue
	logic [QUEUES-1:0]    afVec;           // Almost full per queue
	logic [QUEUES-1:0]    nonEmpty;        // One read unit present
	logic [QUEUES-1:0]    configured;      // Queue in use
	logic [1:0]           queueCount;      // Configured queues minus one
	// Shared bus ownership
	logic                 busOwned;
	logic [CHIP_W-1:0]    pollSlot;        // Polled ownership slot
	logic [CHIP_W-1:0]    chipCode;
	logic                 readAccept;

	assign chipCode = {chip_code_bit2, chip_code_bit1, chip_code_bit0};

	// Select bus targets this device
	function automatic logic chipMatch(input logic [SEL_W-1:0] sel,
	                                   input logic [CHIP_W-1:0] code);
		chipMatch = (sel[SEL_W-1:QSEL_W] == code);
	endfunction

	// Lane extraction, little-endian
	function automatic logic [DATA_W-1:0] laneOf(
			input logic [DATA_W-1:0] word,
			input logic [1:0]        idx,
			input logic [2:0]        lanes);
		logic [DATA_W-1:0] sh;
		sh = '0;
		if (lanes == 3'h4) begin
			sh = word >> (LANE_W * idx);
			laneOf = {27'h000_0000, sh[LANE_W-1:0]};
		end else if (lanes == 3'h2) begin
			sh = word >> (2 * LANE_W * idx);
			laneOf = {18'h0_0000, sh[2*LANE_W-1:0]};
		end else begin
			laneOf = word;
		end
	endfunction

	// Setup caught while master reset is held
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flagMode <= flag_bus_mode_select ?
				MQWPF_POLLED : MQWPF_DIRECT;
			cfgConv  <= width_convert_enable;
			cfgIw    <= input_width_select;
			cfgOw    <= output_width_select;
		end
	end

	// Width table, common to all queues
	always_comb begin
		writeLanes = 3'h1;
		readLanes  = 3'h1;
		if (cfgConv) begin
			if (cfgIw)
				writeLanes = cfgOw ? 3'h4 : 3'h2;
			else
				readLanes  = cfgOw ? 3'h4 : 3'h2;
		end
		capacity = LVL_W'(CAP36 * writeLanes);
	end

	// Per-queue flags, kept for every queue
	always_comb begin
		for (int q = 0; q < QUEUES; q++) begin
			fullVec[q]  = (level[q] >= capacity);
			afVec[q]    = ((capacity - level[q]) <= afOffset[q]);
			nonEmpty[q] = (level[q] >= LVL_W'(writeLanes));
			configured[q] = (q <= queueCount);
		end
	end

	// Write lands only after the settle edge, never when full
	assign writeAccept = writeRequest && deviceSelected && !selPending
		&& !write_select_enable && !fullVec[activeQueue];
	assign readAccept  = readStrobe && nonEmpty[readQueue];

	// Queue and device selection
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			activeQueue    <= 2'h0;
			deviceSelected <= 1'b0;
			selPending     <= 1'b0;
		end else begin
			selPending <= write_select_enable;
			if (write_select_enable) begin
				activeQueue    <= write_queue_select[QSEL_W-1:0];
				deviceSelected <= chipMatch(write_queue_select,
				                            chipCode);
			end
		end
	end

	// Active full flag, registered on the clock
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			queue_full_n <= 1'b1;
			queueFullOe  <= 1'b0;
		end else begin
			queue_full_n <= ~fullVec[activeQueue];
			queueFullOe  <= deviceSelected;
		end
	end

	// Narrow writes packed low lane first
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			packLane    <= 2'h0;
			packedWord  <= 36'h0_0000_0000;
			packedValid <= 1'b0;
			packedQueue <= 2'h0;
		end else begin
			packedValid <= 1'b0;
			if (write_select_enable) begin
				// Partial word dropped on a queue switch
				packLane <= 2'h0;
			end else if (writeAccept) begin
				packedQueue <= activeQueue;
				if (writeLanes == 3'h4)
					packedWord[LANE_W*packLane +: LANE_W]
						<= writeData[LANE_W-1:0];
				else if (writeLanes == 3'h2)
					packedWord[2*LANE_W*packLane[0] +: 2*LANE_W]
						<= writeData[2*LANE_W-1:0];
				else
					packedWord <= writeData;
				if (3'(packLane) == writeLanes - 3'h1) begin
					packLane    <= 2'h0;
					packedValid <= 1'b1;
				end else begin
					packLane <= packLane + 2'h1;
				end
			end
		end
	end

	// Fill levels in write units, all queues live
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int q = 0; q < QUEUES; q++) begin
				level[q]   <= '0;
				readSub[q] <= 2'h0;
			end
		end else begin
			for (int q = 0; q < QUEUES; q++) begin
				logic inc;
				logic dec;
				logic [LVL_W-1:0] decBy;
				inc   = writeAccept && (activeQueue == q);
				dec   = readAccept && (readQueue == q);
				decBy = '0;
				if (dec) begin
					if (readLanes > 3'h1) begin
						// Narrow reads: one unit per full lane set
						if (3'(readSub[q]) == readLanes - 3'h1) begin
							readSub[q] <= 2'h0;
							decBy = LVL_W'(1);
						end else begin
							readSub[q] <= readSub[q] + 2'h1;
						end
					end else begin
						decBy = LVL_W'(writeLanes);
					end
				end
				level[q] <= level[q] + LVL_W'(inc) - decBy;
			end
		end
	end

	// Read side lane and per-queue valid flags
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			readLaneData <= 36'h0_0000_0000;
			read_valid_n <= 4'hF;
		end else begin
			if (readAccept)
				readLaneData <= laneOf(readWordIn,
					readSub[readQueue], readLanes);
			read_valid_n <= ~nonEmpty;
		end
	end

	// Bus ownership, direct or polled
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			busOwned <= 1'b0;
			pollSlot <= 3'h0;
		end else begin
			unique case (flagMode)
				MQWPF_DIRECT: begin
					if (almost_full_bus_strobe)
						busOwned <= chipMatch(write_queue_select,
						                      chipCode);
				end
				MQWPF_POLLED: begin
					// Slot walks all eight chip codes in turn
					pollSlot <= pollSlot + 3'h1;
					busOwned <= (pollSlot == chipCode);
				end
			endcase
		end
	end

	// Status bus value and enable
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			almost_full_status_bus <= 4'hF;
			almostFullStatusOe     <= 1'b0;
		end else begin
			// Unused queues read high, no meaning
			almost_full_status_bus <= ~(afVec & configured);
			almostFullStatusOe     <= busOwned;
		end
	end

	// APB: one wait state, pready from a flop
	logic apbDone;
	logic apbHit;
	logic [31:0] rdValue;
	assign apbDone = psel && penable && pready;

	// Address decode and read mux
	always_comb begin
		apbHit  = 1'b1;
		rdValue = 32'h0000_0000;
		if (paddr == ADDR_CONFIG)
			rdValue = {30'h0000_0000, queueCount};
		else if (paddr == ADDR_STATUS) begin
			rdValue[ST_FULL +: QUEUES]  = fullVec;
			rdValue[ST_AFULL +: QUEUES] = afVec;
			rdValue[ST_ACTQ +: QSEL_W]  = activeQueue;
			rdValue[ST_SEL]    = deviceSelected;
			rdValue[ST_MODE]   = (flagMode == MQWPF_POLLED);
			rdValue[ST_CONV]   = cfgConv;
			rdValue[ST_IW]     = cfgIw;
			rdValue[ST_OW]     = cfgOw;
			rdValue[ST_OWNBUS] = busOwned;
		end else if (paddr[7:4] == ADDR_AFOFS0[7:4] && paddr[3:2] != 2'h3
		             || paddr[7:4] == ADDR_AFOFS0[7:4])
			rdValue = {17'h0_0000, afOffset[paddr[3:2]]};
		else if (paddr[7:4] == ADDR_LEVEL0[7:4])
			rdValue = {17'h0_0000, level[paddr[3:2]]};
		else
			apbHit = 1'b0;
		if (paddr[1:0] != 2'h0)
			apbHit = 1'b0;
	end

	// Handshake and read data
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				prdata  <= (apbHit && !pwrite) ? rdValue : 32'h0000_0000;
				// Status and level are read-only
				pslverr <= !apbHit || (pwrite && (paddr == ADDR_STATUS
					|| paddr[7:4] == ADDR_LEVEL0[7:4]));
			end
		end
	end

	// Writable registers, applied on the completing edge
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			queueCount <= CONFIG_RST;
			for (int q = 0; q < QUEUES; q++)
				afOffset[q] <= AFOFS_RST;
		end else if (apbDone && pwrite && !pslverr && apbHit) begin
			if (paddr == ADDR_CONFIG)
				queueCount <= pwdata[1:0];
			else if (paddr[7:4] == ADDR_AFOFS0[7:4])
				afOffset[paddr[3:2]] <= pwdata[LVL_W-1:0];
		end
	end

	// Checks
	logic activeFull;
	assign activeFull = fullVec[activeQueue];

	property p_full_follows_select;
		@(posedge clk) disable iff (!reset_n)
		write_select_enable |=> ##1 (queue_full_n == !$past(activeFull));
	endproperty
	a_full_follows_select: assert property (p_full_follows_select)
		else $error("full flag not tracking new queue");

	property p_no_early_write;
		@(posedge clk) disable iff (!reset_n)
		write_select_enable |-> !writeAccept ##1 !writeAccept;
	endproperty
	a_no_early_write: assert property (p_no_early_write)
		else $error("write accepted before second edge");

	property p_full_blocks;
		@(posedge clk) disable iff (!reset_n)
		writeAccept |-> !activeFull && level[activeQueue] < capacity;
	endproperty
	a_full_blocks: assert property (p_full_blocks)
		else $error("write into a full queue");

	property p_oe_release;
		@(posedge clk) disable iff (!reset_n)
		(write_select_enable && !chipMatch(write_queue_select, chipCode))
		|=> ##1 !queueFullOe;
	endproperty
	a_oe_release: assert property (p_oe_release)
		else $error("full flag driven by unselected chip");

	property p_bus_release;
		@(posedge clk) disable iff (!reset_n)
		(flagMode == MQWPF_DIRECT && almost_full_bus_strobe
		 && !chipMatch(write_queue_select, chipCode))
		|=> ##1 !almostFullStatusOe;
	endproperty
	a_bus_release: assert property (p_bus_release)
		else $error("status bus driven without ownership");

	property p_bus_bit0;
		@(posedge clk) disable iff (!reset_n)
		$past(reset_n) && $past(configured[0])
		|-> almost_full_status_bus[0] == !$past(afVec[0]);
	endproperty
	a_bus_bit0: assert property (p_bus_bit0)
		else $error("queue 0 status on wrong bit");

	property p_level_bound;
		@(posedge clk) disable iff (!reset_n)
		level[activeQueue] <= capacity;
	endproperty
	a_level_bound: assert property (p_level_bound)
		else $error("level beyond capacity");

	property p_valid_units;
		@(posedge clk) disable iff (!reset_n)
		$past(reset_n) |-> read_valid_n[0] ==
			!($past(level[0]) >= LVL_W'($past(writeLanes)));
	endproperty
	a_valid_units: assert property (p_valid_units)
		else $error("output valid not in read units");

	property p_width_stable;
		@(posedge clk) disable iff (!reset_n)
		$past(reset_n) |-> $stable(writeLanes) && $stable(readLanes);
	endproperty
	a_width_stable: assert property (p_width_stable)
		else $error("port width changed outside reset");

endmodule

// File: mqwpf_ctrl_model.sv
`timescale 1ns/1ns
// Write-side system controller: select bus, strobe and write data
module mqwpf_ctrl_model (
	input  wire logic                         clk,
	output logic      [mqwpf_pkg::SEL_W-1:0]  write_queue_select,
	output logic                              write_select_enable,
	output logic                              writeRequest,
	output logic      [mqwpf_pkg::DATA_W-1:0] writeData,
	output logic                              almost_full_bus_strobe
);
	import mqwpf_pkg::*;
	// Idle levels from time zero
	initial begin
		write_queue_select     = '0;
		write_select_enable    = 1'b0;
		writeRequest           = 1'b0;
		writeData              = '0;
		almost_full_bus_strobe = 1'b0;
	end
	// One device addressed at a time, chip code picks one of eight
	// Write held wrHold edges counted from the select edge
	task automatic select_queue(input logic [2:0] chip,
			input logic [1:0] q, input int wrHold);
		int i;
		@(posedge clk);
		write_queue_select  <= {chip, q};
		write_select_enable <= 1'b1;
		writeRequest        <= (wrHold > 0);
		@(posedge clk);
		write_select_enable <= 1'b0;
		for (i = 1; i < wrHold; i++)
			@(posedge clk);
		writeRequest <= 1'b0;
	endtask
	// Back-to-back writes; data inverted once released, never left stale
	task automatic burst(input int n, input logic [DATA_W-1:0] base);
		int i;
		@(posedge clk);
		writeRequest <= 1'b1;
		writeData    <= base;
		for (i = 1; i < n; i++) begin
			@(posedge clk);
			writeData <= base + DATA_W'(i);
		end
		@(posedge clk);
		writeRequest <= 1'b0;
		writeData    <= ~writeData;
	endtask
	// Direct-mode claim: select bus names the chip, strobe marks it
	task automatic own_bus(input logic [2:0] chip);
		@(posedge clk);
		write_queue_select     <= {chip, 2'b00};
		almost_full_bus_strobe <= 1'b1;
		@(posedge clk);
		almost_full_bus_strobe <= 1'b0;
	endtask
endmodule

// File: mqwpf_write_port_flags_tb.sv
`timescale 1ns/1ns
// Bench: controller model on the write port, APB for setup and levels
module mqwpf_write_port_flags_tb;
	import mqwpf_pkg::*;
	localparam int         WORDS = 8;    // Short queues keep fills brief
	localparam logic [2:0] OURS  = 3'h5; // Chip code of this device
	logic        clk;
	logic        reset_n = 1'b0;
	logic        fm = 1'b0;
	logic        conv = 1'b0;
	logic        iw = 1'b0;
	logic        ow = 1'b0;
	logic [2:0]  chip = OURS;
	logic        readStrobe = 1'b0;
	logic [1:0]  readQueue = 2'h0;
	logic [35:0] readWordIn = '0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = '0;
	logic [4:0]  write_queue_select;
	logic        write_select_enable, writeRequest, almost_full_bus_strobe;
	logic [35:0] writeData, packedWord, readLaneData, lastWord;
	logic [1:0]  packedQueue, lastQueue;
	logic        packedValid, queue_full_n, queueFullOe, almostFullStatusOe;
	logic [3:0]  almost_full_status_bus, read_valid_n;
	logic [31:0] prdata, rdata;
	logic        pready, pslverr, err;
	int          bad_count = 0;
	int          checked = 0;
	int          acceptCount = 0;
	logic        abort = 1'b0; // Set when a bounded wait runs out
	// Shared full line with its pull-up; only an owner pulls it
	wire         fullLine = queueFullOe ? queue_full_n : 1'b1;

	mqwpf_write_port_flags #(.QUEUE_WORDS(WORDS)) dut (
		.clk, .reset_n, .flag_bus_mode_select(fm),
		.width_convert_enable(conv), .input_width_select(iw),
		.output_width_select(ow), .chip_code_bit0(chip[0]),
		.chip_code_bit1(chip[1]), .chip_code_bit2(chip[2]),
		.write_queue_select, .write_select_enable, .writeRequest,
		.writeData, .packedWord, .packedValid, .packedQueue,
		.queue_full_n, .queueFullOe, .almost_full_bus_strobe,
		.almost_full_status_bus, .almostFullStatusOe, .readStrobe,
		.readQueue, .readWordIn, .readLaneData, .read_valid_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	mqwpf_ctrl_model ctl (
		.clk, .write_queue_select, .write_select_enable,
		.writeRequest, .writeData, .almost_full_bus_strobe);

	// Clock at 50 MHz
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Tally of words the design hands on
	always @(posedge clk) begin
		if (packedValid === 1'b1) begin
			acceptCount <= acceptCount + 1;
			lastWord    <= packedWord;
			lastQueue   <= packedQueue;
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Setup pins are caught while reset is low
	task automatic do_reset(input logic c, input logic i, input logic o,
			input logic f);
		@(posedge clk);
		reset_n <= 1'b0;
		conv    <= c;
		iw      <= i;
		ow      <= o;
		fm      <= f;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
	endtask
	// APB cycle; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge clk);
		rdata = prdata;
		err   = pslverr;
		if (n == 20) begin
			chk(pready, 1'b1);
			abort = 1'b1;
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
			input logic ee);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdata, e);
		chk(err, ee);
	endtask
	// Select, then look one edge later at owner and full flag
	task automatic sel(input logic [2:0] c, input logic [1:0] q,
			input int h, input logic eOe, input logic eFull);
		ctl.select_queue(c, q, h);
		@(posedge clk);
		#1;
		chk(queueFullOe, eOe);
		chk(queue_full_n, eFull);
	endtask
	task automatic wait_full(input logic e);
		int n;
		for (n = 0; n < 10 && queue_full_n !== e; n++)
			@(posedge clk);
		chk(queue_full_n, e);
		if (n == 10)
			abort = 1'b1;
	endtask
	// One read-port event; idle word inverted afterwards
	task automatic rd(input logic [1:0] q, input logic [35:0] w);
		@(posedge clk);
		readStrobe <= 1'b1;
		readQueue  <= q;
		readWordIn <= w;
		@(posedge clk);
		readStrobe <= 1'b0;
		readWordIn <= ~w;
		#1;
	endtask
	// Hang guard; a bounded wait that ran out ends the run early too
	initial begin
		for (int g = 0; g < 20000 && !abort; g++)
			@(posedge clk);
		bad_count++;
		wrap_up();
	end

	initial begin
		int i;
		do_reset(1'b0, 1'b0, 1'b0, 1'b0);
		chk(queue_full_n, 1'b1);
		chk(queueFullOe, 1'b0);
		chk(almost_full_status_bus, 4'hF);
		rdchk(ADDR_CONFIG, 32'(CONFIG_RST), 1'b0);
		rdchk(ADDR_AFOFS0, 32'(AFOFS_RST), 1'b0);
		rdchk(8'h08, 32'h0000_0000, 1'b1);
		rdchk(8'h02, 32'h0000_0000, 1'b1);
		apb(1'b1, ADDR_STATUS, 32'h0000_FFFF);
		chk(err, 1'b1);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, ADDR_AFOFS0 + 8'(4 * i), 32'h0000_0002);
			rdchk(ADDR_AFOFS0 + 8'(4 * i), 32'h0000_0002, 1'b0);
		end
		$display("test registers done");
		ctl.select_queue(OURS, 2'd1, 0);
		#1 chk(queueFullOe, 1'b0);
		@(posedge clk);
		#1 chk(queueFullOe, 1'b1);
		ctl.burst(WORDS, 36'h0_0000_0100);
		wait_full(1'b0);
		chk(acceptCount, WORDS);
		chk(lastQueue, 2'd1);
		ctl.burst(1, 36'h0_0000_0AAA);
		rdchk(ADDR_LEVEL0 + 8'h04, WORDS, 1'b0);
		sel(OURS, 2'd2, 3, 1'b1, 1'b1);
		chk(acceptCount, WORDS + 1);
		chk(lastQueue, 2'd2);
		sel(OURS, 2'd1, 0, 1'b1, 1'b0);
		ctl.own_bus(OURS);
		for (i = 0; i < 10 && almostFullStatusOe !== 1'b1; i++)
			@(posedge clk);
		if (i == 10)
			abort = 1'b1;
		chk(almostFullStatusOe, 1'b1);
		chk(almost_full_status_bus, 4'b1101);
		sel(OURS, 2'd2, 0, 1'b1, 1'b1);
		rd(2'd1, 36'h0_0000_0100);
		repeat (4) @(posedge clk);
		sel(OURS, 2'd1, 0, 1'b1, 1'b1);
		sel(3'h3, 2'd0, 0, 1'b0, 1'b1);
		chk(fullLine, 1'b1);
		ctl.burst(1, 36'h0_0000_0005);
		repeat (3) @(posedge clk);
		chk(acceptCount, WORDS + 1);
		ctl.own_bus(3'h3);
		repeat (3) @(posedge clk);
		chk(almostFullStatusOe, 1'b0);
		$display("test direct mode done");
		do_reset(1'b1, 1'b0, 1'b1, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk(rdata[14:11], 4'b1010);
		sel(OURS, 2'd0, 0, 1'b1, 1'b1);
		ctl.burst(WORDS, 36'h0_0000_0200);
		wait_full(1'b0);
		rd(2'd0, 36'h8_4C2A_1357);
		chk(readLaneData, 36'h0_0000_0157);
		rd(2'd0, 36'h8_4C2A_1357);
		chk(readLaneData, 36'h0_0000_0109);
		rd(2'd0, 36'h8_4C2A_1357);
		repeat (4) @(posedge clk);
		chk(queue_full_n, 1'b0);
		rd(2'd0, 36'h8_4C2A_1357);
		wait_full(1'b1);
		$display("test narrow read done");
		do_reset(1'b1, 1'b1, 1'b1, 1'b1);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk(rdata[14:11], 4'b1111);
		for (i = 0; i < 40 && almostFullStatusOe !== 1'b1; i++)
			@(posedge clk);
		if (i == 40)
			abort = 1'b1;
		chk(almostFullStatusOe, 1'b1);
		sel(OURS, 2'd2, 0, 1'b1, 1'b1);
		ctl.burst(3, 36'h0_0000_01A0);
		repeat (4) @(posedge clk);
		chk(read_valid_n, 4'hF);
		ctl.burst(1, 36'h0_0000_01A3);
		for (i = 0; i < 10 && read_valid_n !== 4'hB; i++)
			@(posedge clk);
		if (i == 10)
			abort = 1'b1;
		chk(read_valid_n, 4'hB);
		chk(lastWord, {9'h1A3, 9'h1A2, 9'h1A1, 9'h1A0});
		chk(lastQueue, 2'd2);
		sel(OURS, 2'd3, 0, 1'b1, 1'b1);
		ctl.burst(4, 36'h0_0000_0011);
		for (i = 0; i < 10 && read_valid_n !== 4'h3; i++)
			@(posedge clk);
		if (i == 10)
			abort = 1'b1;
		chk(read_valid_n, 4'h3);
		$display("test narrow write done");
		// Half-width ports: x18 in, then x18 out
		do_reset(1'b1, 1'b1, 1'b0, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk(rdata[14:11], 4'b0110);
		sel(OURS, 2'd0, 0, 1'b1, 1'b1);
		ctl.burst(1, 36'h0_0000_0ABC);
		repeat (4) @(posedge clk);
		chk(read_valid_n, 4'hF);
		ctl.burst(1, 36'h0_0000_0ABD);
		for (i = 0; i < 10 && read_valid_n !== 4'hE; i++)
			@(posedge clk);
		if (i == 10)
			abort = 1'b1;
		chk(read_valid_n, 4'hE);
		chk(lastWord, {18'h0_0ABD, 18'h0_0ABC});
		do_reset(1'b1, 1'b0, 1'b0, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk(rdata[14:11], 4'b0010);
		sel(OURS, 2'd0, 0, 1'b1, 1'b1);
		ctl.burst(1, 36'h8_4C2A_1357);
		rd(2'd0, 36'h8_4C2A_1357);
		chk(readLaneData, 36'h0_0002_1357);
		rd(2'd0, 36'h8_4C2A_1357);
		chk(readLaneData, 36'h0_0002_130A);
		$display("test half width done");
		wrap_up();
	end
endmodule
